// ==== inc/pie_pkg.sv ====
// Constants, register map and node table of the prioritized interrupt and event transfer block
package pie_pkg;

  // Sizes
  localparam int NODE_CNT = 8;                       // Interrupt nodes
  localparam int CH_CNT   = 8;                       // Event transfer channels
  localparam int LVL_CNT  = 16;                      // Priority levels
  localparam int LVL_W    = 4;                       // Priority field width
  localparam int NODE_W   = 3;                       // Node index width
  localparam int CH_W     = 3;                       // Channel index width
  localparam int ADDR_W   = 8;                       // Register address width
  localparam int DATA_W   = 16;                      // Register data width
  localparam int PTR_W    = 16;                      // Transfer pointer width
  localparam int CNT_W    = 8;                       // Transfer counter width
  localparam int TRAP_W   = 7;                       // Trap number width
  localparam int SEG_W    = 8;                       // Vector segment width
  localparam int VEC_W    = 24;                      // Full vector address width
  localparam int EXT_CNT  = 2;                       // Fast external inputs

  // Interrupt response figure in CPU clocks
  localparam int RESP_MAX_CYC = 8;

  // Register offsets (word index on the register port)
  localparam logic [ADDR_W-1:0] OFS_NODE_BASE = 8'h00;  // Node control, one per node
  localparam logic [ADDR_W-1:0] OFS_CH_BASE   = 8'h10;  // Channel triples, four words apart
  localparam logic [ADDR_W-1:0] OFS_VECSEL    = 8'h40;  // Vector segment select
  localparam logic [ADDR_W-1:0] OFS_EDGE      = 8'h41;  // Fast input edge select
  localparam logic [ADDR_W-1:0] OFS_STAT      = 8'h42;  // Sticky event status, read only
  localparam logic [ADDR_W-1:0] OFS_CLR       = 8'h43;  // Status clear, write only
  localparam logic [ADDR_W-1:0] OFS_IEN       = 8'h44;  // Status interrupt enable
  localparam logic [ADDR_W-1:0] OFS_LVL       = 8'h45;  // Active level mask, read only
  localparam int               CH_STRIDE_SH  = 2;      // Channel stride as a shift
  localparam logic [1:0]        CH_SUB_SRC    = 2'd0;   // Source pointer word
  localparam logic [1:0]        CH_SUB_DST    = 2'd1;   // Destination pointer word
  localparam logic [1:0]        CH_SUB_CTL    = 2'd2;   // Counter and mode word

  // Node control fields
  localparam int NC_LVL_LO = 0;                      // Priority level, four bits
  localparam int NC_EN     = 6;                      // Enable flag
  localparam int NC_REQ    = 7;                      // Request flag
  localparam int NC_XFER   = 8;                      // Route to event transfer
  localparam int NC_CH_LO  = 9;                      // Channel select, three bits

  // Channel control fields
  localparam int CC_CNT_LO = 0;                      // Transfer counter, eight bits
  localparam int CC_BYTE   = 8;                      // Byte transfer when set
  localparam int CC_INCS   = 9;                      // Increment source pointer
  localparam int CC_INCD   = 10;                     // Increment destination pointer
  localparam int CC_CONT   = 11;                     // Continuous mode

  // Reset values
  localparam logic [DATA_W-1:0] NODE_RST = 16'h0000;
  localparam logic [SEG_W-1:0]  SEG_RST  = 8'h00;

  // Trap number of each node; the vector offset is four times this
  localparam logic [TRAP_W-1:0] NODE_TRAP [NODE_CNT] = '{
    7'h10, 7'h11, 7'h12, 7'h13, 7'h30, 7'h31, 7'h3F, 7'h58
  };

  // Fast external inputs land on these nodes
  localparam int EXT_NODE0 = 2;
  localparam int EXT_NODE1 = 3;

  // Edge select codes
  localparam logic [1:0] EDGE_OFF  = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_FALL = 2'b10;
  localparam logic [1:0] EDGE_BOTH = 2'b11;

  // Controller states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REQ,
    ST_XFER
  } pie_state_t;

endpackage : pie_pkg

// ==== verilog/pie_ctrl.sv ====
// Prioritized interrupt controller with eight single-cycle event transfer channels
//
// Contract
// - Interrupt request reaches CPU within eight clocks
// - Each node routes to interrupt or transfer
// - Standard service branches through node vector
// - Transfer steals one cycle, no vector
// - Move byte/word, then increment chosen pointers
// - Counter decrements unless continuous mode
// - Counter zero raises source's standard interrupt
// - Eight channels, own pointers and counters
// - Node register holds request, enable, priority
// - Sixteen priority levels rank pending requests
// - Only strictly higher priority preempts service
// - Each node owns a dedicated vector
// - Fast inputs detect rising, falling, both
// - Trap number raises matching node's interrupt
// - Software request bit acts like hardware
// - Vector offset equals four times trap
// - Segment register supplies upper vector bits
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module pie_ctrl
  import pie_pkg::*;
(
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        nrst,
  // Register port
  input  wire logic [pie_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [pie_pkg::DATA_W-1:0]  regWrData,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [pie_pkg::DATA_W-1:0]  regRdData,
  // Peripheral request pulses, same clock
  input  wire logic [pie_pkg::NODE_CNT-1:0] srcReq,
  // Fast external interrupt pins, asynchronous
  input  wire logic [pie_pkg::EXT_CNT-1:0] extPin,
  // Software trap from the CPU
  input  wire logic                        trapStrobe,
  input  wire logic [pie_pkg::TRAP_W-1:0]  trapNum,
  // CPU interrupt handshake
  output logic                             intReq,
  output logic      [pie_pkg::VEC_W-1:0]   intVector,
  output logic      [pie_pkg::LVL_W-1:0]   intLevel,
  input  wire logic                        intAck,
  input  wire logic                        intReturn,
  // Event transfer memory move
  output logic                             cpuHold,
  output logic                             memMove,
  output logic                             memByte,
  output logic      [pie_pkg::PTR_W-1:0]   memSrc,
  output logic      [pie_pkg::PTR_W-1:0]   memDst,
  // Event interrupt line
  output logic                             irq
);
  import pie_pkg::*;

  // Register storage
  logic [DATA_W-1:0]    nodeCtl [NODE_CNT];   // Node control words
  logic [PTR_W-1:0]     chSrc   [CH_CNT];     // Channel source pointers
  logic [PTR_W-1:0]     chDst   [CH_CNT];     // Channel destination pointers
  logic [DATA_W-1:0]    chCtl   [CH_CNT];     // Channel counter and mode
  logic [SEG_W-1:0]     vecSel;               // Vector segment select
  logic [2*EXT_CNT-1:0] edgeSel;              // Two bits per fast input
  logic [CH_CNT-1:0]    evStat;               // Sticky counter-zero events
  logic [CH_CNT-1:0]    evEn;                 // Event interrupt enables
  logic [LVL_CNT-1:0]   actLvl;               // Levels currently in service

  // Control state
  pie_state_t           state;                // Controller state
  logic [NODE_W-1:0]    selNode;              // Node being served
  logic [CH_W-1:0]      selCh;                // Channel of a transfer

  // Fast input synchronisers
  logic [EXT_CNT-1:0]   extMeta;              // First stage, read only by extSync
  logic [EXT_CNT-1:0]   extSync;              // Second stage
  logic [EXT_CNT-1:0]   extLast;              // Previous synchronised level
  logic [EXT_CNT-1:0]   extHit;               // Selected edge seen

  // Arbitration results
  logic                 winValid;             // Some enabled request is pending
  logic [NODE_W-1:0]    winNode;              // Winning node
  logic [LVL_W-1:0]     winLvl;               // Its level
  logic [LVL_W-1:0]     curLvl;               // Highest level in service
  logic                 curBusy;              // Any service active
  logic                 winPreempt;           // Winner beats current service
  logic                 winIsXfer;            // Winner goes to a channel
  logic [CH_W-1:0]      winCh;                // Winner's channel

  // Per node hardware set and clear terms
  logic [NODE_CNT-1:0]  hwSet;                // Request from any hardware cause
  logic [NODE_CNT-1:0]  hwClr;                // Request taken by service
  logic                 xferEnd;              // Transfer brought counter to zero
  logic [CNT_W-1:0]     xferCnt;              // Counter of the active channel

  // Write decode helpers
  logic                 wrNode;               // Write hits a node register
  logic                 wrCh;                 // Write hits a channel register
  logic [CH_W-1:0]      wrChIdx;              // Addressed channel
  logic [1:0]           wrChSub;              // Word within channel triple
  logic [NODE_W-1:0]    wrNodeIdx;            // Addressed node

  // Address decode, shared by read and write
  always_comb begin
    wrNode    = (regAddr >= OFS_NODE_BASE) && (regAddr < OFS_NODE_BASE + ADDR_W'(NODE_CNT));
    wrCh      = (regAddr >= OFS_CH_BASE) && (regAddr < OFS_CH_BASE + ADDR_W'(CH_CNT << CH_STRIDE_SH));
    wrNodeIdx = NODE_W'(regAddr - OFS_NODE_BASE);
    wrChIdx   = CH_W'((regAddr - OFS_CH_BASE) >> CH_STRIDE_SH);
    wrChSub   = 2'((regAddr - OFS_CH_BASE));
  end

  // Fast input synchroniser; edge logic reads the second stage and extLast, never the first
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      extMeta <= '0;
      extSync <= '0;
      extLast <= '0;
    end else begin
      extMeta <= extPin;
      extSync <= extMeta;
      extLast <= extSync;
    end
  end

  // Programmable edge detection on the fast inputs
  always_comb begin
    for (int e = 0; e < EXT_CNT; e++) begin
      case (edgeSel[2*e +: 2])
        EDGE_RISE: extHit[e] = extSync[e] & ~extLast[e];
        EDGE_FALL: extHit[e] = ~extSync[e] & extLast[e];
        EDGE_BOTH: extHit[e] = extSync[e] ^ extLast[e];
        default:   extHit[e] = 1'b0;
      endcase
    end
  end

  // Gather every hardware cause that raises a node's request
  always_comb begin
    for (int n = 0; n < NODE_CNT; n++) begin
      hwSet[n] = srcReq[n] | (trapStrobe && (trapNum == NODE_TRAP[n]));
    end
    hwSet[EXT_NODE0] = hwSet[EXT_NODE0] | extHit[0];
    hwSet[EXT_NODE1] = hwSet[EXT_NODE1] | extHit[1];
  end

  // Highest enabled level wins; strict compare keeps the lowest index on ties
  always_comb begin
    winValid = 1'b0;
    winNode  = '0;
    winLvl   = '0;
    for (int n = 0; n < NODE_CNT; n++) begin
      if (nodeCtl[n][NC_REQ] && nodeCtl[n][NC_EN]) begin
        if (!winValid || (nodeCtl[n][NC_LVL_LO +: LVL_W] > winLvl)) begin
          winValid = 1'b1;
          winNode  = NODE_W'(n);
          winLvl   = nodeCtl[n][NC_LVL_LO +: LVL_W];
        end
      end
    end
  end

  // Current service level is the top bit of the active mask
  always_comb begin
    curLvl  = '0;
    curBusy = |actLvl;
    for (int l = 0; l < LVL_CNT; l++) begin
      if (actLvl[l]) begin
        curLvl = LVL_W'(l);
      end
    end
  end

  // Level 0 never beats an idle CPU, so it stays a parked level
  always_comb begin
    winPreempt = winValid && (winLvl > curLvl);
    winCh      = nodeCtl[winNode][NC_CH_LO +: CH_W];
    xferCnt    = chCtl[selCh][CC_CNT_LO +: CNT_W];
    // An exhausted, non-continuous channel hands the node back to the CPU
    winIsXfer  = nodeCtl[winNode][NC_XFER] &&
                 ((chCtl[winCh][CC_CNT_LO +: CNT_W] != '0) || chCtl[winCh][CC_CONT]);
    xferEnd    = (state == ST_XFER) && !chCtl[selCh][CC_CONT] && (xferCnt == CNT_W'(1));
  end

  // Service takes the request flag: ack for interrupts, otherwise any transfer cycle except the one that brings the counter to zero
  always_comb begin
    hwClr = '0;
    if ((state == ST_REQ) && intAck) begin
      hwClr[selNode] = 1'b1;
    end
    if ((state == ST_XFER) && !xferEnd) begin
      hwClr[selNode] = 1'b1;
    end
  end

  // Node control registers; a hardware set wins over any clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int n = 0; n < NODE_CNT; n++) begin
        nodeCtl[n] <= NODE_RST;
      end
    end else begin
      for (int n = 0; n < NODE_CNT; n++) begin
        if (regWr && wrNode && (wrNodeIdx == NODE_W'(n))) begin
          nodeCtl[n]         <= regWrData;
          nodeCtl[n][NC_REQ] <= regWrData[NC_REQ] | hwSet[n];
        end else if (hwSet[n]) begin
          nodeCtl[n][NC_REQ] <= 1'b1;
        end else if (hwClr[n]) begin
          nodeCtl[n][NC_REQ] <= 1'b0;
        end
      end
    end
  end

  // Channel registers; the transfer cycle's update overrides a same-cycle write
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int c = 0; c < CH_CNT; c++) begin
        chSrc[c] <= '0;
        chDst[c] <= '0;
        chCtl[c] <= '0;
      end
    end else begin
      if (regWr && wrCh) begin
        case (wrChSub)
          CH_SUB_SRC: chSrc[wrChIdx] <= regWrData;
          CH_SUB_DST: chDst[wrChIdx] <= regWrData;
          CH_SUB_CTL: chCtl[wrChIdx] <= regWrData;
          default:    ;
        endcase
      end
      if (state == ST_XFER) begin
        // Step is one for bytes, two for words
        if (chCtl[selCh][CC_INCS]) begin
          chSrc[selCh] <= chSrc[selCh] + (chCtl[selCh][CC_BYTE] ? PTR_W'(1) : PTR_W'(2));
        end
        if (chCtl[selCh][CC_INCD]) begin
          chDst[selCh] <= chDst[selCh] + (chCtl[selCh][CC_BYTE] ? PTR_W'(1) : PTR_W'(2));
        end
        if (!chCtl[selCh][CC_CONT]) begin
          chCtl[selCh][CC_CNT_LO +: CNT_W] <= xferCnt - CNT_W'(1);
        end
      end
    end
  end

  // Controller sequence and the CPU-facing outputs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state     <= ST_IDLE;
      selNode   <= '0;
      selCh     <= '0;
      intReq    <= 1'b0;
      intVector <= '0;
      intLevel  <= '0;
      cpuHold   <= 1'b0;
      memMove   <= 1'b0;
      memByte   <= 1'b0;
      memSrc    <= '0;
      memDst    <= '0;
    end else begin
      cpuHold <= 1'b0;
      memMove <= 1'b0;
      case (state)
        ST_IDLE: begin
          // One cycle of arbitration, so the CPU sees the request well inside its budget
          if (winPreempt) begin
            selNode <= winNode;
            if (winIsXfer) begin
              // One stolen cycle: move strobe and hold together, no vector
              selCh   <= winCh;
              cpuHold <= 1'b1;
              memMove <= 1'b1;
              memByte <= chCtl[winCh][CC_BYTE];
              memSrc  <= chSrc[winCh];
              memDst  <= chDst[winCh];
              state   <= ST_XFER;
            end else begin
              intReq    <= 1'b1;
              intVector <= {vecSel, (VEC_W-SEG_W)'({NODE_TRAP[winNode], 2'b00})};
              intLevel  <= winLvl;
              state     <= ST_REQ;
            end
          end
        end
        ST_REQ: begin
          // Vector stands until the CPU takes it
          if (intAck) begin
            intReq <= 1'b0;
            state  <= ST_IDLE;
          end
        end
        ST_XFER: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Active level mask: acceptance pushes a level, return drops the top one
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      actLvl <= '0;
    end else begin
      logic [LVL_CNT-1:0] lvlNext;
      lvlNext = actLvl;
      if (intReturn && curBusy) begin
        lvlNext[curLvl] = 1'b0;
      end
      if ((state == ST_REQ) && intAck) begin
        lvlNext[intLevel] = 1'b1;
      end
      actLvl <= lvlNext;
    end
  end

  // Configuration registers written by software
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      vecSel  <= SEG_RST;
      edgeSel <= '0;
      evEn    <= '0;
    end else if (regWr) begin
      if (regAddr == OFS_VECSEL) begin
        vecSel <= regWrData[SEG_W-1:0];
      end
      if (regAddr == OFS_EDGE) begin
        edgeSel <= regWrData[2*EXT_CNT-1:0];
      end
      if (regAddr == OFS_IEN) begin
        evEn <= regWrData[CH_CNT-1:0];
      end
    end
  end

  // Sticky counter-zero events; a new event wins over a same-cycle clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      evStat <= '0;
    end else begin
      logic [CH_CNT-1:0] evSet;
      evSet = '0;
      if (xferEnd) begin
        evSet[selCh] = 1'b1;
      end
      if (regWr && (regAddr == OFS_CLR)) begin
        evStat <= (evStat & ~regWrData[CH_CNT-1:0]) | evSet;
      end else begin
        evStat <= evStat | evSet;
      end
    end
  end

  // Level interrupt, registered so it follows the status by one cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evStat & evEn);
    end
  end

  // Read data, valid in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= '0;
    end else if (regRd) begin
      if (wrNode) begin
        regRdData <= nodeCtl[wrNodeIdx];
      end else if (wrCh) begin
        case (wrChSub)
          CH_SUB_SRC: regRdData <= chSrc[wrChIdx];
          CH_SUB_DST: regRdData <= chDst[wrChIdx];
          CH_SUB_CTL: regRdData <= chCtl[wrChIdx];
          default:    regRdData <= '0;
        endcase
      end else begin
        case (regAddr)
          OFS_VECSEL: regRdData <= DATA_W'(vecSel);
          OFS_EDGE:   regRdData <= DATA_W'(edgeSel);
          OFS_STAT:   regRdData <= DATA_W'(evStat);
          OFS_IEN:    regRdData <= DATA_W'(evEn);
          OFS_LVL:    regRdData <= actLvl;
          default:    regRdData <= '0;
        endcase
      end
    end else begin
      regRdData <= '0;
    end
  end

endmodule : pie_ctrl

// ==== verif/pie_cpu_model.sv ====
// CPU core stand-in: accepts interrupt requests and signals end of service
`timescale 1ns/100ps
module pie_cpu_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // Interrupt handshake
  input  wire logic       intReq,
  output logic            intAck,
  output logic            intReturn,
  // Test control: ack delay and return request
  input  wire logic [3:0] ackDly,
  input  wire logic       retGo
);
  logic [3:0] waitCnt;  // Cycles the request has been pending

  // Ack after the chosen delay; a slow core keeps the request standing longer
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      waitCnt   <= 4'h0;
      intAck    <= 1'b0;
      intReturn <= 1'b0;
    end else begin
      intReturn <= retGo;
      if (intReq && !intAck && waitCnt >= ackDly) begin
        intAck  <= 1'b1;
        waitCnt <= 4'h0;
      end else begin
        intAck  <= 1'b0;
        waitCnt <= intReq ? waitCnt + 4'h1 : 4'h0;
      end
    end
  end
endmodule : pie_cpu_model

// ==== verif/pie_ctrl_sva.sv ====
// Port-level checker of the interrupt and event transfer controller
`timescale 1ns/100ps
module pie_ctrl_sva
  import pie_pkg::*;
(
  // Clock and reset
  input wire logic                       ref_clk,
  input wire logic                       nrst,
  // Register read side
  input wire logic                       regRd,
  input wire logic [pie_pkg::DATA_W-1:0] regRdData,
  // CPU handshake and transfer strobes
  input wire logic                       intReq,
  input wire logic [pie_pkg::VEC_W-1:0]  intVector,
  input wire logic [pie_pkg::LVL_W-1:0]  intLevel,
  input wire logic                       intAck,
  input wire logic                       cpuHold,
  input wire logic                       memMove
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_req_holds: assert property (
    intReq && !intAck |=> intReq && $stable(intVector) && $stable(intLevel))
    else $error("Request changed before ack");
  a_ack_drops: assert property (
    intReq && intAck |=> !intReq) else $error("Request kept after ack");
  a_move_single: assert property (
    memMove |=> !memMove) else $error("Move longer than one cycle");
  a_hold_with_move: assert property (
    memMove |-> cpuHold) else $error("Move without stolen cycle");
  a_move_no_vector: assert property (
    memMove |-> !intReq) else $error("Move beside a vector request");
  a_level_nonzero: assert property (
    intReq |-> intLevel != 4'h0) else $error("Level zero serviced");
  a_vec_aligned: assert property (
    intReq |-> intVector[1:0] == 2'b00 && intVector[15:9] == 7'h00)
    else $error("Vector offset not four times a trap");
  a_rd_quiet: assert property (
    !regRd |=> regRdData == 16'h0000) else $error("Read data outside read slot");
endmodule : pie_ctrl_sva

bind pie_ctrl pie_ctrl_sva u_sva (
  .ref_clk(ref_clk), .nrst(nrst), .regRd(regRd), .regRdData(regRdData),
  .intReq(intReq), .intVector(intVector), .intLevel(intLevel),
  .intAck(intAck), .cpuHold(cpuHold), .memMove(memMove)
);

// ==== verif/testbench.sv ====
// Self-checking bench of the interrupt and event transfer controller
`timescale 1ns/100ps
module testbench;
  import pie_pkg::*;
  logic ref_clk, nrst, regWr, regRd, trapStrobe, intReq, intAck, intReturn;
  logic cpuHold, memMove, memByte, irq, retGo;
  logic [7:0] regAddr, srcReq;
  logic [15:0] regWrData, regRdData, memSrc, memDst;
  logic [1:0] extPin;
  logic [6:0] trapNum;
  logic [23:0] intVector;
  logic [3:0] intLevel, ackDly;
  int err_count = 0;
  int n_compared = 0;

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  pie_ctrl DUT (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .srcReq(srcReq), .extPin(extPin),
    .trapStrobe(trapStrobe), .trapNum(trapNum), .intReq(intReq), .intVector(intVector),
    .intLevel(intLevel), .intAck(intAck), .intReturn(intReturn), .cpuHold(cpuHold),
    .memMove(memMove), .memByte(memByte), .memSrc(memSrc), .memDst(memDst), .irq(irq));
  pie_cpu_model u_cpu (.ref_clk(ref_clk), .nrst(nrst), .intReq(intReq), .intAck(intAck),
    .intReturn(intReturn), .ackDly(ackDly), .retGo(retGo));

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic end_sim;
    $display("Compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask : tick

  // One-cycle register write and read
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a; regWrData <= d; regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    regAddr <= a; regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    chk("regRdData", regRdData, exp);
  endtask : rd

  task automatic pulse(input logic [7:0] m);
    @(posedge ref_clk);
    srcReq <= m;
    @(posedge ref_clk);
    srcReq <= 8'h00;
  endtask : pulse

  // Bounded wait for a request, then vector and level compare
  task automatic wait_int(input logic [15:0] ofs, input logic [3:0] lvl);
    int i;
    for (i = 0; i < RESP_MAX_CYC; i++) begin
      tick();
      if (intReq === 1'b1) break;
    end
    if (i == RESP_MAX_CYC) begin err_count++; end_sim(); end
    chk("intVector", intVector, {8'hA5, ofs});
    chk("intLevel", intLevel, lvl);
  endtask : wait_int

  task automatic wait_move(input logic [15:0] s, input logic [15:0] d, input logic b);
    int i;
    for (i = 0; i < RESP_MAX_CYC; i++) begin
      tick();
      if (memMove === 1'b1) break;
    end
    if (i == RESP_MAX_CYC) begin err_count++; end_sim(); end
    chk("memSrc", memSrc, s);
    chk("memDst", memDst, d);
    chk("memByte", memByte, b);
    chk("cpuHold", cpuHold, 1'b1);
  endtask : wait_move

  // Bounded wait for the core to take the pending request
  task automatic wait_ack;
    int i;
    for (i = 0; i < 12 && intReq !== 1'b0; i++) tick();
    if (intReq !== 1'b0) begin err_count++; end_sim(); end
  endtask : wait_ack

  // End of service once the core has acked
  task automatic ret;
    wait_ack();
    @(posedge ref_clk);
    retGo <= 1'b1;
    @(posedge ref_clk);
    retGo <= 1'b0;
  endtask : ret

  initial begin
    logic seen;
    nrst = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 8'h00; regWrData = 16'h0000;
    srcReq = 8'h00; extPin = 2'b10; trapStrobe = 1'b0; trapNum = 7'h00; retGo = 1'b0;
    ackDly = 4'h0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(8'h00, 16'h0000);
    wr(8'h7F, 16'hFFFF);
    rd(8'h7F, 16'h0000);
    wr(OFS_VECSEL, 16'h00A5);
    // Two nodes at one level requested together
    wr(8'h00, 16'h0047);
    wr(8'h01, 16'h0047);
    pulse(8'h03);
    wait_int(16'h0040, 4'h7);
    ret();
    wait_int(16'h0044, 4'h7);
    ret();
    // Software request bit, then equal level must wait, higher preempts
    wr(8'h01, 16'h00C5);
    wait_int(16'h0044, 4'h5);
    ackDly <= 4'h3;
    wait_ack();
    wr(8'h00, 16'h00C5);
    seen = 1'b0;
    repeat (10) begin tick(); seen |= intReq; end
    chk("blocked intReq", seen, 1'b0);
    wr(8'h04, 16'h0046);
    pulse(8'h10);
    wait_int(16'h00C0, 4'h6);
    ret();
    ret();
    wait_int(16'h0040, 4'h5);
    ret();
    // Fast inputs: input 0 on rising, input 1 on falling
    wr(OFS_EDGE, 16'h0009);
    wr(8'h02, 16'h0044);
    wr(8'h03, 16'h0044);
    @(posedge ref_clk);
    extPin <= 2'b11;
    wait_int(16'h0048, 4'h4);
    ret();
    @(posedge ref_clk);
    extPin <= 2'b01;
    wait_int(16'h004C, 4'h4);
    ret();
    // Software trap
    wr(8'h07, 16'h0042);
    @(posedge ref_clk);
    trapStrobe <= 1'b1; trapNum <= 7'h58;
    @(posedge ref_clk);
    trapStrobe <= 1'b0;
    wait_int(16'h0160, 4'h2);
    ret();
    // Channel 3: two word moves, counter runs out, node vector follows
    wr(OFS_IEN, 16'h0008);
    wr(8'h1C, 16'h1000);
    wr(8'h1D, 16'h2000);
    wr(8'h1E, 16'h0602);
    wr(8'h05, 16'h0743);
    pulse(8'h20);
    wait_move(16'h1000, 16'h2000, 1'b0);
    pulse(8'h20);
    wait_move(16'h1002, 16'h2002, 1'b0);
    wait_int(16'h00C4, 4'h3);
    rd(8'h1E, 16'h0600);
    rd(OFS_STAT, 16'h0008);
    chk("irq", irq, 1'b1);
    wr(OFS_IEN, 16'h0000);
    tick();
    chk("irq masked", irq, 1'b0);
    wr(OFS_IEN, 16'h0008);
    wr(OFS_CLR, 16'h0008);
    rd(OFS_STAT, 16'h0000);
    chk("irq cleared", irq, 1'b0);
    ret();
    // Continuous byte mode keeps the counter
    wr(8'h1E, 16'h0F01);
    pulse(8'h20);
    wait_move(16'h1004, 16'h2004, 1'b1);
    pulse(8'h20);
    wait_move(16'h1005, 16'h2005, 1'b1);
    rd(8'h1E, 16'h0F01);
    end_sim();
  end
endmodule : testbench
